// file: pwmcap_pkg.sv
// package: register map, field positions and shared types for the pwm timer with capture
// Behaviour
// - prescaler divides by value plus one; zero stops prescaler and counter
// - clock select divides by 2,4,8,16 for codes 0-3, undivided when top bit set
// - upper prescale bytes give dead-zone gaps 1 and 0 in selector clocks
// - control bits 5 and 4 enable dead-zone generators 1 and 0
// - mode bit zero is one-shot, one reloads from period on reaching zero
// - invert bit set inverts the pulse-width outputs
// - run bit one starts the timer, zero stops it
// - output cycle lasts reload value plus one timer clocks
// - compare at or above reload keeps the output high all cycle
// - compare zero gives one clock high and reload clocks low
// - compare writes take effect only from the next output cycle
// - counter register reads the live 16-bit down counter
// - timer interrupt enable gates the timer flag onto the interrupt
// - timer flag set when counter reaches zero, cleared by writing one
// - with capture on, rising edge latches counter to rise latch, falling to fall
// - capture control bits 1 and 2 enable rising and falling capture interrupts
// - a capture interrupt with the capture flag clear reloads the down counter with the period value
// - enabled dead-zone delays rising edges of its output pair by the gap
// - capture flag set on enabled edge, cleared by one; while set no reload
// - rise and fall latched indicators set on latch, cleared by writing zero
// - capture enable zero disables latching and capture interrupts
package pwmcap_pkg;
	localparam logic [11:0] PWMCAP_OFS_PSC    = 12'h000;
	localparam logic [11:0] PWMCAP_OFS_DIV    = 12'h004;
	localparam logic [11:0] PWMCAP_OFS_CTL    = 12'h008;
	localparam logic [11:0] PWMCAP_OFS_PERIOD = 12'h00c;
	localparam logic [11:0] PWMCAP_OFS_CMP0   = 12'h010;
	localparam logic [11:0] PWMCAP_OFS_CNT    = 12'h014;
	localparam logic [11:0] PWMCAP_OFS_CMP1   = 12'h01c;
	localparam logic [11:0] PWMCAP_OFS_CMP2   = 12'h028;
	localparam logic [11:0] PWMCAP_OFS_CMP3   = 12'h034;
	localparam logic [11:0] PWMCAP_OFS_INTEN  = 12'h040;
	localparam logic [11:0] PWMCAP_OFS_INTSTS = 12'h044;
	localparam logic [11:0] PWMCAP_OFS_CAPCTL = 12'h050;
	localparam logic [11:0] PWMCAP_OFS_RLATCH = 12'h058;
	localparam logic [11:0] PWMCAP_OFS_FLATCH = 12'h05c;
	localparam logic [11:0] PWMCAP_OFS_PCEN   = 12'h07c;
	localparam int PWMCAP_CTL_RUN   = 0;
	localparam int PWMCAP_CTL_INV   = 2;
	localparam int PWMCAP_CTL_MODE  = 3;
	localparam int PWMCAP_CTL_GAP0  = 4;
	localparam int PWMCAP_CTL_GAP1  = 5;
	localparam int PWMCAP_CAP_INV   = 0;
	localparam int PWMCAP_CAP_RIE   = 1;
	localparam int PWMCAP_CAP_FIE   = 2;
	localparam int PWMCAP_CAP_EN    = 3;
	localparam int PWMCAP_CAP_IF    = 4;
	localparam int PWMCAP_CAP_RLF   = 6;
	localparam int PWMCAP_CAP_FLF   = 7;
	localparam int PWMCAP_PCEN_CAPIN = 8;
	localparam logic [31:0] PWMCAP_RST_WORD = 32'h00000000;
	localparam logic [1:0] PWMCAP_RESP_OKAY   = 2'b00;
	localparam logic [1:0] PWMCAP_RESP_SLVERR = 2'b10;
	typedef struct packed {
		logic [7:0] gap_length_1;
		logic [7:0] gap_length_0;
		logic [7:0] prescale_value;
		logic [2:0] clock_divide_code;
	} pwmcap_clk_cfg_t;
	typedef enum logic [1:0] {
		PWMCAP_IDLE,
		PWMCAP_RUN,
		PWMCAP_DONE
	} pwmcap_cnt_state_t;
endpackage

// file: pwmcap_top.sv
// module: pwm timer with capture, axi4-lite register slave
`timescale 1ns/100ps
module pwmcap_top
	import pwmcap_pkg::*;
#(
	parameter int CNT_W = 16
) (
	input  wire logic        sys_clk_in,
	input  wire logic        rst_n_in,
	input  wire logic [11:0] s_axi_awaddr_in,
	input  wire logic        s_axi_awvalid_in,
	output logic             s_axi_awready_out,
	input  wire logic [31:0] s_axi_wdata_in,
	input  wire logic [3:0]  s_axi_wstrb_in,
	input  wire logic        s_axi_wvalid_in,
	output logic             s_axi_wready_out,
	output logic [1:0]       s_axi_bresp_out,
	output logic             s_axi_bvalid_out,
	input  wire logic        s_axi_bready_in,
	input  wire logic [11:0] s_axi_araddr_in,
	input  wire logic        s_axi_arvalid_in,
	output logic             s_axi_arready_out,
	output logic [31:0]      s_axi_rdata_out,
	output logic [1:0]       s_axi_rresp_out,
	output logic             s_axi_rvalid_out,
	input  wire logic        s_axi_rready_in,
	input  wire logic        capture_pin_in,
	output logic [3:0]       pwm_out,
	output logic             irq_out
);

	// ==========================================================
	// registers
	pwmcap_clk_cfg_t    clk_cfg_q;
	logic [5:0]         ctl_q;
	logic [CNT_W-1:0]   period_q;
	logic [CNT_W-1:0]   cmp_q [4];
	logic [CNT_W-1:0]   cmp_act_q [4];
	logic               irq_on_q;
	logic               zero_flag_q;
	logic [3:0]         capctl_q;
	logic               cap_if_q;
	logic               rlf_q;
	logic               flf_q;
	logic [CNT_W-1:0]   rise_latch_value_q;
	logic [CNT_W-1:0]   fall_latch_value_q;
	logic [8:0]         pcen_q;
	logic [CNT_W-1:0]   live_count_q;
	pwmcap_cnt_state_t  state_q;

	// ==========================================================
	// axi4-lite write path: address and data taken in either order
	logic        aw_held_q;
	logic        w_held_q;
	logic [11:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0]  wstrb_q;
	logic        ar_held_q;
	logic [11:0] araddr_q;
	wire         aw_take = s_axi_awvalid_in && s_axi_awready_out;
	wire         w_take  = s_axi_wvalid_in && s_axi_wready_out;
	wire         wr_fire = aw_held_q && w_held_q && !s_axi_bvalid_out;
	wire         ar_take = s_axi_arvalid_in && s_axi_arready_out;
	wire         rd_fire = ar_held_q && !s_axi_rvalid_out;
	wire         full_wr = wr_fire && (wstrb_q[1:0] == 2'b11);
	wire         lo_wr   = wr_fire && wstrb_q[0];
	wire         we_psc  = wr_fire && awaddr_q == PWMCAP_OFS_PSC;
	wire         we_div  = lo_wr && awaddr_q == PWMCAP_OFS_DIV;
	wire         we_ctl  = lo_wr && awaddr_q == PWMCAP_OFS_CTL;
	wire         we_per  = full_wr && awaddr_q == PWMCAP_OFS_PERIOD;
	wire         we_ien  = lo_wr && awaddr_q == PWMCAP_OFS_INTEN;
	wire         we_ists = lo_wr && awaddr_q == PWMCAP_OFS_INTSTS;
	wire         we_cap  = lo_wr && awaddr_q == PWMCAP_OFS_CAPCTL;
	wire         we_pcen = wr_fire && awaddr_q == PWMCAP_OFS_PCEN;
	wire [11:0]  cmp_ofs [4] = '{PWMCAP_OFS_CMP0, PWMCAP_OFS_CMP1,
		PWMCAP_OFS_CMP2, PWMCAP_OFS_CMP3};
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			aw_held_q <= 1'b0;
			w_held_q  <= 1'b0;
			awaddr_q  <= 12'h000;
			wdata_q   <= PWMCAP_RST_WORD;
			wstrb_q   <= 4'h0;
			s_axi_bvalid_out <= 1'b0;
			s_axi_bresp_out  <= PWMCAP_RESP_OKAY;
		end else begin
			if (aw_take) begin
				aw_held_q <= 1'b1;
				awaddr_q  <= s_axi_awaddr_in;
			end else if (wr_fire) begin
				aw_held_q <= 1'b0;
			end
			if (w_take) begin
				w_held_q <= 1'b1;
				wdata_q  <= s_axi_wdata_in;
				wstrb_q  <= s_axi_wstrb_in;
			end else if (wr_fire) begin
				w_held_q <= 1'b0;
			end
			if (wr_fire) begin
				s_axi_bvalid_out <= 1'b1;
				s_axi_bresp_out  <= decode_ok(awaddr_q) ? PWMCAP_RESP_OKAY : PWMCAP_RESP_SLVERR;
			end else if (s_axi_bready_in) begin
				s_axi_bvalid_out <= 1'b0;
			end
		end
	end

	assign s_axi_awready_out = !aw_held_q;
	assign s_axi_wready_out  = !w_held_q;
	assign s_axi_arready_out = !ar_held_q;

	function automatic logic decode_ok(input logic [11:0] a);
		case (a)
			PWMCAP_OFS_PSC, PWMCAP_OFS_DIV, PWMCAP_OFS_CTL, PWMCAP_OFS_PERIOD,
			PWMCAP_OFS_CMP0, PWMCAP_OFS_CNT, PWMCAP_OFS_CMP1, PWMCAP_OFS_CMP2,
			PWMCAP_OFS_CMP3, PWMCAP_OFS_INTEN, PWMCAP_OFS_INTSTS, PWMCAP_OFS_CAPCTL,
			PWMCAP_OFS_RLATCH, PWMCAP_OFS_FLATCH, PWMCAP_OFS_PCEN: decode_ok = 1'b1;
			default: decode_ok = 1'b0;
		endcase
	endfunction

	// ==========================================================
	// read path
	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = PWMCAP_RST_WORD;
		case (araddr_q)
			PWMCAP_OFS_PSC:    rd_mux = {clk_cfg_q.gap_length_1, clk_cfg_q.gap_length_0,
				8'h00, clk_cfg_q.prescale_value};
			PWMCAP_OFS_DIV:    rd_mux = {29'h0, clk_cfg_q.clock_divide_code};
			PWMCAP_OFS_CTL:    rd_mux = {26'h0, ctl_q};
			PWMCAP_OFS_PERIOD: rd_mux = {16'h0, period_q};
			PWMCAP_OFS_CMP0:   rd_mux = {16'h0, cmp_q[0]};
			PWMCAP_OFS_CNT:    rd_mux = {16'h0, live_count_q};
			PWMCAP_OFS_CMP1:   rd_mux = {16'h0, cmp_q[1]};
			PWMCAP_OFS_CMP2:   rd_mux = {16'h0, cmp_q[2]};
			PWMCAP_OFS_CMP3:   rd_mux = {16'h0, cmp_q[3]};
			PWMCAP_OFS_INTEN:  rd_mux = {31'h0, irq_on_q};
			PWMCAP_OFS_INTSTS: rd_mux = {31'h0, zero_flag_q};
			PWMCAP_OFS_CAPCTL: rd_mux = {24'h0, flf_q, rlf_q, 1'b0, cap_if_q, capctl_q};
			PWMCAP_OFS_RLATCH: rd_mux = {16'h0, rise_latch_value_q};
			PWMCAP_OFS_FLATCH: rd_mux = {16'h0, fall_latch_value_q};
			PWMCAP_OFS_PCEN:   rd_mux = {23'h0, pcen_q};
			default:           rd_mux = PWMCAP_RST_WORD;
		endcase
	end

	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ar_held_q <= 1'b0;
			araddr_q  <= 12'h000;
			s_axi_rvalid_out <= 1'b0;
			s_axi_rdata_out  <= PWMCAP_RST_WORD;
			s_axi_rresp_out  <= PWMCAP_RESP_OKAY;
		end else begin
			if (ar_take) begin
				ar_held_q <= 1'b1;
				araddr_q  <= s_axi_araddr_in;
			end else if (rd_fire) begin
				ar_held_q <= 1'b0;
			end
			if (rd_fire) begin
				s_axi_rvalid_out <= 1'b1;
				s_axi_rdata_out  <= rd_mux;
				s_axi_rresp_out  <= decode_ok(araddr_q) ? PWMCAP_RESP_OKAY : PWMCAP_RESP_SLVERR;
			end else if (s_axi_rready_in) begin
				s_axi_rvalid_out <= 1'b0;
			end
		end
	end

	// ==========================================================
	// clock chain: prescaler then selector, both as enables
	logic [7:0] psc_cnt_q;
	logic [3:0] div_cnt_q;
	logic       tick_d_q;
	wire        psc_tick = (clk_cfg_q.prescale_value != 8'h00)
		&& (psc_cnt_q == clk_cfg_q.prescale_value);
	logic [3:0] div_mask;
	always_comb begin
		case (clk_cfg_q.clock_divide_code[1:0])
			2'b00:   div_mask = 4'h1;
			2'b01:   div_mask = 4'h3;
			2'b10:   div_mask = 4'h7;
			default: div_mask = 4'hf;
		endcase
	end
	wire tmr_tick = psc_tick && (clk_cfg_q.clock_divide_code[2]
		|| ((div_cnt_q & div_mask) == div_mask));

	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			psc_cnt_q <= 8'h00;
			div_cnt_q <= 4'h0;
			tick_d_q  <= 1'b0;
		end else begin
			tick_d_q  <= tmr_tick;
			psc_cnt_q <= psc_tick || clk_cfg_q.prescale_value == 8'h00 ? 8'h00 : psc_cnt_q + 8'h01;
			if (psc_tick) begin
				div_cnt_q <= div_cnt_q + 4'h1;
			end
		end
	end

	// ==========================================================
	// capture input: synchronise, optional invert, edge detect
	logic [1:0] cap_sync_q;
	wire        cap_lvl  = cap_sync_q[1] ^ capctl_q[PWMCAP_CAP_INV];
	logic       cap_prev_q;
	wire        cap_gate = capctl_q[PWMCAP_CAP_EN] && pcen_q[PWMCAP_PCEN_CAPIN];
	wire        cap_rise = cap_gate && cap_lvl && !cap_prev_q;
	wire        cap_fall = cap_gate && !cap_lvl && cap_prev_q;
	wire        cap_irq  = (cap_rise && capctl_q[PWMCAP_CAP_RIE])
		|| (cap_fall && capctl_q[PWMCAP_CAP_FIE]);
	wire        cap_reload = cap_irq && !cap_if_q;

	// ==========================================================
	// down counter
	wire cnt_zero  = live_count_q == '0;
	wire run_wr    = we_ctl && wdata_q[PWMCAP_CTL_RUN];
	wire cyc_end   = tmr_tick && state_q == PWMCAP_RUN && cnt_zero;
	wire hit_zero  = tmr_tick && state_q == PWMCAP_RUN && live_count_q == {{(CNT_W-1){1'b0}}, 1'b1};

	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			live_count_q <= '0;
			state_q      <= PWMCAP_IDLE;
		end else begin
			case (state_q)
				PWMCAP_IDLE: begin
					if (run_wr) begin
						live_count_q <= period_q;
						state_q      <= PWMCAP_RUN;
					end
				end
				PWMCAP_RUN: begin
					if (!ctl_q[PWMCAP_CTL_RUN]) begin
						state_q <= PWMCAP_IDLE;
					end else if (cap_reload) begin
						live_count_q <= period_q;
					end else if (tmr_tick) begin
						if (!cnt_zero) begin
							live_count_q <= live_count_q - 1'b1;
						end else if (ctl_q[PWMCAP_CTL_MODE]) begin
							live_count_q <= period_q;
						end else begin
							state_q <= PWMCAP_DONE;
						end
					end
				end
				PWMCAP_DONE: begin
					if (run_wr) begin
						live_count_q <= period_q;
						state_q      <= PWMCAP_RUN;
					end else if (!ctl_q[PWMCAP_CTL_RUN]) begin
						state_q <= PWMCAP_IDLE;
					end
				end
				default: state_q <= PWMCAP_IDLE;
			endcase
		end
	end

	// ==========================================================
	// comparators one per output, dead zone one per output pair
	logic [3:0] raw_q;
	logic [3:0] gapped;
	logic [7:0] gap_cnt_q [2];
	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_cmp
			always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
				if (!rst_n_in) begin
					cmp_act_q[g] <= '0;
					cmp_q[g]     <= '0;
					raw_q[g]     <= 1'b0;
				end else begin
					if (full_wr && awaddr_q == cmp_ofs[g]) begin
						cmp_q[g] <= wdata_q[CNT_W-1:0];
					end
					if (state_q != PWMCAP_RUN || cyc_end) begin
						cmp_act_q[g] <= cmp_q[g];
					end
					// high while count <= compare: compare+1 clocks high
					raw_q[g] <= state_q == PWMCAP_RUN && (cmp_act_q[g] >= period_q
						|| live_count_q <= cmp_act_q[g]);
				end
			end
		end
		for (g = 0; g < 2; g++) begin : g_gap
			wire on = ctl_q[PWMCAP_CTL_GAP0 + g];
			wire [7:0] len = g == 0 ? clk_cfg_q.gap_length_0 : clk_cfg_q.gap_length_1;
			// next comparator level: the gap starts on the edge that changes the output
			wire raw_nx = state_q == PWMCAP_RUN && (cmp_act_q[2*g] >= period_q
				|| live_count_q <= cmp_act_q[2*g]);
			always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
				if (!rst_n_in) begin
					gap_cnt_q[g] <= 8'h00;
				end else begin
					if (raw_nx != raw_q[2*g]) begin
						gap_cnt_q[g] <= len;
					end else if (tick_d_q && gap_cnt_q[g] != 8'h00) begin
						gap_cnt_q[g] <= gap_cnt_q[g] - 8'h01;
					end
				end
			end
			// pair: even follows comparator, odd is its complement, both delayed on rise
			wire idle = gap_cnt_q[g] == 8'h00;
			assign gapped[2*g]   = on ? (raw_q[2*g] && idle) : raw_q[2*g];
			assign gapped[2*g+1] = on ? (!raw_q[2*g] && idle && state_q == PWMCAP_RUN)
				: raw_q[2*g+1];
		end
	endgenerate

	// ==========================================================
	// control and status registers
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			clk_cfg_q   <= '0;
			ctl_q       <= 6'h00;
			period_q    <= '0;
			irq_on_q    <= 1'b0;
			zero_flag_q <= 1'b0;
			capctl_q    <= 4'h0;
			cap_if_q    <= 1'b0;
			rlf_q       <= 1'b0;
			flf_q       <= 1'b0;
			rise_latch_value_q <= '0;
			fall_latch_value_q <= '0;
			pcen_q      <= 9'h000;
			cap_sync_q  <= 2'b00;
			cap_prev_q  <= 1'b0;
			pwm_out     <= 4'h0;
			irq_out     <= 1'b0;
		end else begin
			if (we_psc && wstrb_q[0]) clk_cfg_q.prescale_value <= wdata_q[7:0];
			if (we_psc && wstrb_q[2]) clk_cfg_q.gap_length_0 <= wdata_q[23:16];
			if (we_psc && wstrb_q[3]) clk_cfg_q.gap_length_1 <= wdata_q[31:24];
			if (we_div) clk_cfg_q.clock_divide_code <= wdata_q[2:0];
			if (we_ctl) ctl_q <= wdata_q[5:0] & 6'h3d;
			if (we_per) period_q <= wdata_q[CNT_W-1:0];
			if (we_ien) irq_on_q <= wdata_q[0];
			if (we_pcen && wstrb_q[0]) pcen_q[3:0] <= wdata_q[3:0];
			if (we_pcen && wstrb_q[1]) pcen_q[8] <= wdata_q[8];
			// set wins over a same-cycle clear
			if (hit_zero || (cyc_end && period_q == '0)) begin
				zero_flag_q <= 1'b1;
			end else if (we_ists && wdata_q[0]) begin
				zero_flag_q <= 1'b0;
			end
			if (we_cap) capctl_q <= wdata_q[3:0];
			if (cap_irq) begin
				cap_if_q <= 1'b1;
			end else if (we_cap && wdata_q[PWMCAP_CAP_IF]) begin
				cap_if_q <= 1'b0;
			end
			if (cap_rise) begin
				rise_latch_value_q <= live_count_q;
				rlf_q <= 1'b1;
			end else if (we_cap && !wdata_q[PWMCAP_CAP_RLF]) begin
				rlf_q <= 1'b0;
			end
			if (cap_fall) begin
				fall_latch_value_q <= live_count_q;
				flf_q <= 1'b1;
			end else if (we_cap && !wdata_q[PWMCAP_CAP_FLF]) begin
				flf_q <= 1'b0;
			end
			cap_sync_q <= {cap_sync_q[0], capture_pin_in};
			cap_prev_q <= cap_gate ? cap_lvl : 1'b0;
			pwm_out    <= (gapped ^ {4{ctl_q[PWMCAP_CTL_INV]}}) & pcen_q[3:0];
			irq_out    <= (zero_flag_q && irq_on_q) || cap_if_q;
		end
	end

endmodule

// file: pwmcap_assertions.sv
// checker: register bus handshake assertions for pwmcap_top
`timescale 1ns/100ps
module pwmcap_checker
	import pwmcap_pkg::*;
(
	input wire logic        sys_clk_in,
	input wire logic        rst_n_in,
	input wire logic        s_axi_awvalid_in,
	input wire logic        s_axi_awready_out,
	input wire logic        s_axi_wvalid_in,
	input wire logic        s_axi_wready_out,
	input wire logic        s_axi_bvalid_out,
	input wire logic        s_axi_bready_in,
	input wire logic        s_axi_arvalid_in,
	input wire logic        s_axi_arready_out,
	input wire logic [31:0] s_axi_rdata_out,
	input wire logic [1:0]  s_axi_rresp_out,
	input wire logic        s_axi_rvalid_out,
	input wire logic        s_axi_rready_in
);
	// =====
	// bus timing, one domain
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (!rst_n_in);
	aw_refused_a: assert property (s_axi_awvalid_in && s_axi_awready_out
		|=> !s_axi_awready_out) else $error("write address taken twice");
	w_refused_a: assert property (s_axi_wvalid_in && s_axi_wready_out
		|=> !s_axi_wready_out) else $error("write data taken twice");
	wr_answer_a: assert property (s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in
		&& s_axi_wready_out |=> !s_axi_bvalid_out ##1 s_axi_bvalid_out)
		else $error("write answer late");
	b_release_a: assert property (s_axi_bvalid_out && s_axi_bready_in |=> !s_axi_bvalid_out)
		else $error("write answer not released");
	rd_answer_a: assert property (s_axi_arvalid_in && s_axi_arready_out
		|=> !s_axi_rvalid_out ##1 s_axi_rvalid_out) else $error("read answer late");
	r_hold_a: assert property (s_axi_rvalid_out && !s_axi_rready_in
		|=> s_axi_rvalid_out && $stable(s_axi_rdata_out)) else $error("read data dropped");
	r_release_a: assert property (s_axi_rvalid_out && s_axi_rready_in |=> !s_axi_rvalid_out)
		else $error("read answer not released");
	ar_refused_a: assert property (s_axi_arvalid_in && s_axi_arready_out
		|=> !s_axi_arready_out) else $error("read address taken twice");
	slverr_data_a: assert property (s_axi_rvalid_out && s_axi_rresp_out == PWMCAP_RESP_SLVERR
		|-> s_axi_rdata_out == 32'h0) else $error("error read carries data");
endmodule
bind pwmcap_top pwmcap_checker u_checker (
	.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
	.s_axi_awvalid_in(s_axi_awvalid_in), .s_axi_awready_out(s_axi_awready_out),
	.s_axi_wvalid_in(s_axi_wvalid_in), .s_axi_wready_out(s_axi_wready_out),
	.s_axi_bvalid_out(s_axi_bvalid_out), .s_axi_bready_in(s_axi_bready_in),
	.s_axi_arvalid_in(s_axi_arvalid_in), .s_axi_arready_out(s_axi_arready_out),
	.s_axi_rdata_out(s_axi_rdata_out), .s_axi_rresp_out(s_axi_rresp_out),
	.s_axi_rvalid_out(s_axi_rvalid_out), .s_axi_rready_in(s_axi_rready_in)
);

// file: pwmcap_pin_model.sv
// partner: capture signal source and power stage watching both gate pairs
`timescale 1ns/100ps
module pwmcap_pin_model (
	input  wire logic        sys_clk_in,
	input  wire logic        pulse_go_in,
	input  wire logic [15:0] pulse_len_in,
	input  wire logic [3:0]  gate_in,
	output logic             capture_pin_out,
	output logic [15:0]      overlap_cnt_out
);
	logic [15:0] left_q;
	initial begin
		capture_pin_out = 1'b0;
		left_q = 16'h0000;
		overlap_cnt_out = 16'h0000;
	end
	// one high pulse of the asked length per request, low otherwise
	always @(posedge sys_clk_in) begin
		if (pulse_go_in) begin
			left_q <= pulse_len_in;
			capture_pin_out <= 1'b1;
		end else if (left_q > 16'h0001) begin
			left_q <= left_q - 16'h0001;
		end else begin
			left_q <= 16'h0000;
			capture_pin_out <= 1'b0;
		end
	end
	// both switches of one leg on together would short the supply
	always @(posedge sys_clk_in) begin
		if ((gate_in[0] && gate_in[1]) || (gate_in[2] && gate_in[3])) begin
			overlap_cnt_out <= overlap_cnt_out + 16'h0001;
		end
	end
endmodule

// file: pwm_timer_with_capture_tb.sv
// testbench: register map, waveform, timer flag and capture checks for pwmcap_top
`timescale 1ns/100ps
module pwm_timer_with_capture_tb;
	import pwmcap_pkg::*;
	typedef struct packed {
		logic [11:0] addr;
		logic [31:0] wval;
		logic [31:0] rexp;
		logic [1:0]  resp;
	} pwmcap_row_t;
	logic        sys_clk, rst_n, awvalid, wvalid, bready, arvalid, rready, go;
	logic        awready, wready, bvalid, arready, rvalid, irq, pin;
	logic [11:0] awaddr, araddr;
	logic [31:0] wdata, rdata, rd;
	logic [3:0]  wstrb, pwm, prev;
	logic [1:0]  bresp, rresp, rs;
	logic [15:0] plen, ovl, ov0;
	int          err_total, checks, tk, run_n[4], hi_len[4], lo_len[4];
	pwmcap_row_t rows[16];

	pwmcap_top DUT (
		.sys_clk_in(sys_clk), .rst_n_in(rst_n), .s_axi_awaddr_in(awaddr),
		.s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
		.s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
		.s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
		.s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
		.s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
		.s_axi_rready_in(rready), .capture_pin_in(pin), .pwm_out(pwm), .irq_out(irq)
	);
	pwmcap_pin_model u_far (
		.sys_clk_in(sys_clk), .pulse_go_in(go), .pulse_len_in(plen),
		.gate_in(pwm), .capture_pin_out(pin), .overlap_cnt_out(ovl)
	);
	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end
	// =====
	// pulse length monitor: length of the last high and low level per output
	always @(posedge sys_clk) begin
		for (int i = 0; i < 4; i++) begin
			if (pwm[i] !== prev[i]) begin
				if (prev[i]) hi_len[i] <= run_n[i];
				else lo_len[i] <= run_n[i];
				run_n[i] <= 1;
			end else run_n[i] <= run_n[i] + 1;
		end
		prev <= pwm;
	end
	// =====
	// bus and compare tasks
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do begin
			@(posedge sys_clk);
			n++;
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
		end while (!(bvalid === 1'b1) && n < 64);
		rs = bresp;
		chk("write answer", 32'h1, {31'h0, n < 64});
	endtask
	task automatic rd_reg(input logic [11:0] a);
		int n;
		n = 0;
		araddr <= a;
		arvalid <= 1'b1;
		do begin
			@(posedge sys_clk);
			n++;
			if (arvalid && arready) arvalid <= 1'b0;
		end while (!(rvalid === 1'b1) && n < 64);
		rd = rdata;
		rs = rresp;
		chk("read answer", 32'h1, {31'h0, n < 64});
	endtask
	task automatic rchk(input string nm, input logic [11:0] a, input logic [31:0] exp);
		rd_reg(a);
		chk(nm, exp, rd);
	endtask
	task automatic settle(input int c);
		repeat (c) @(posedge sys_clk);
	endtask
	task automatic pulse(input logic [15:0] len);
		plen <= len;
		go <= 1'b1;
		@(posedge sys_clk);
		go <= 1'b0;
		settle(len + 16'd30);
	endtask
	task automatic finish_test;
		if (err_total == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		settle(30000);
		err_total++;
		finish_test();
	end
	// =====
	// main sequence
	initial begin
		rows = '{'{12'h000, 32'hffffffff, 32'hffff00ff, 2'h0}, '{12'h004, 32'hff, 32'h7, 2'h0},
			'{12'h008, 32'h3c, 32'h3c, 2'h0}, '{12'h00c, 32'hffffffff, 32'hffff, 2'h0},
			'{12'h010, 32'hffffffff, 32'hffff, 2'h0}, '{12'h014, 32'hffff, 32'h0, 2'h0},
			'{12'h01c, 32'hffffffff, 32'hffff, 2'h0}, '{12'h028, 32'hffffffff, 32'hffff, 2'h0},
			'{12'h034, 32'hffffffff, 32'hffff, 2'h0}, '{12'h040, 32'hffffffff, 32'h1, 2'h0},
			'{12'h044, 32'hffffffff, 32'h0, 2'h0}, '{12'h050, 32'hff, 32'hf, 2'h0},
			'{12'h058, 32'hffff, 32'h0, 2'h0}, '{12'h05c, 32'hffff, 32'h0, 2'h0},
			'{12'h07c, 32'hffffffff, 32'h10f, 2'h0}, '{12'h018, 32'hffff, 32'h0, 2'h2}};
		// both answer readies stay high for the whole run
		{awvalid, wvalid, bready, arvalid, rready, go} = 6'b001010;
		{awaddr, araddr, wdata, plen} = '0;
		wstrb = 4'hf;
		prev = 4'h0;
		rst_n = 1'b0;
		settle(20);
		rst_n <= 1'b1;
		settle(1);
		foreach (rows[i]) begin
			rchk("reset value", rows[i].addr, 32'h0);
			chk("read resp", {30'h0, rows[i].resp}, {30'h0, rs});
			wr(rows[i].addr, rows[i].wval);
			chk("write resp", {30'h0, rows[i].resp}, {30'h0, rs});
			rchk("readback", rows[i].addr, rows[i].rexp);
		end
		foreach (rows[i]) wr(rows[i].addr, 32'h0);
		wr(12'h050, 32'h10);
		wr(12'h004, 32'h4);
		wr(12'h000, 32'h1);
		wr(12'h008, 32'h8);
		wr(12'h010, 32'h1);
		wr(12'h01c, 32'h0);
		wr(12'h028, 32'h4);
		wr(12'h034, 32'h2);
		wr(12'h00c, 32'h4);
		wr(12'h07c, 32'hf);
		wr(12'h008, 32'h9);
		settle(60);
		chk("high 0", 32'd4, hi_len[0]);
		chk("low 0", 32'd6, lo_len[0]);
		chk("high 1", 32'd2, hi_len[1]);
		chk("low 1", 32'd8, lo_len[1]);
		chk("out 2", 32'h1, {31'h0, pwm[2]});
		chk("high 3", 32'd6, hi_len[3]);
		wr(12'h008, 32'hd);
		settle(40);
		chk("inverted high", 32'd6, hi_len[0]);
		wr(12'h008, 32'h9);
		for (int c = 0; c < 6; c++) begin
			tk = (c == 5) ? 3 : (c == 4) ? 2 : 4 << c;
			wr(12'h000, (c == 5) ? 32'h2 : 32'h1);
			wr(12'h004, (c == 5) ? 32'h4 : 32'(c));
			settle(20 * tk);
			chk("tick high", 32'(2 * tk), hi_len[0]);
			chk("tick low", 32'(3 * tk), lo_len[0]);
		end
		rd_reg(12'h014);
		ov0 = rd[15:0];
		rd_reg(12'h014);
		chk("count moves", 32'h1, {31'h0, rd[15:0] !== ov0});
		wr(12'h000, 32'h0);
		rd_reg(12'h014);
		ov0 = rd[15:0];
		settle(30);
		rchk("count held", 12'h014, {16'h0, ov0});
		wr(12'h000, 32'h1);
		wr(12'h00c, 32'h8);
		wr(12'h010, 32'h4);
		settle(60);
		@(negedge pwm[0]);
		wr(12'h010, 32'h1);
		@(posedge pwm[0]);
		settle(2);
		chk("low before", 32'd8, lo_len[0]);
		@(posedge pwm[0]);
		settle(2);
		chk("low after", 32'd14, lo_len[0]);
		wr(12'h010, 32'h3);
		wr(12'h028, 32'h3);
		wr(12'h000, 32'h01020001);
		wr(12'h008, 32'h39);
		settle(60);
		ov0 = ovl;
		settle(60);
		chk("gap high 0", 32'd4, hi_len[0]);
		chk("gap high 1", 32'd6, hi_len[1]);
		chk("gap high 2", 32'd6, hi_len[2]);
		chk("gap high 3", 32'd8, hi_len[3]);
		chk("overlap", {16'h0, ov0}, {16'h0, ovl});
		wr(12'h00c, 32'h0);
		settle(20);
		rchk("stopped at zero", 12'h014, 32'h0);
		wr(12'h008, 32'h0);
		wr(12'h00c, 32'h4);
		wr(12'h044, 32'h1);
		wr(12'h008, 32'h1);
		settle(40);
		rchk("one shot count", 12'h014, 32'h0);
		rchk("timer flag", 12'h044, 32'h1);
		chk("irq masked", 32'h0, {31'h0, irq});
		wr(12'h040, 32'h1);
		settle(2);
		chk("irq on", 32'h1, {31'h0, irq});
		wr(12'h044, 32'h1);
		rchk("flag cleared", 12'h044, 32'h0);
		chk("irq off", 32'h0, {31'h0, irq});
		wr(12'h040, 32'h0);
		wr(12'h00c, 32'h64);
		wr(12'h008, 32'h9);
		wr(12'h07c, 32'h100);
		pulse(16'd20);
		rchk("capture off", 12'h058, 32'h0);
		wr(12'h050, 32'he);
		pulse(16'd20);
		rchk("capture flags", 12'h050, 32'hde);
		chk("capture irq", 32'h1, {31'h0, irq});
		rd_reg(12'h05c);
		ov0 = 16'h64 - rd[15:0];
		chk("high width", 32'h1, {31'h0, ov0 > 16'd8 && ov0 < 16'd12});
		wr(12'h050, 32'h1e);
		rchk("flags cleared", 12'h050, 32'he);
		chk("irq cleared", 32'h0, {31'h0, irq});
		pulse(16'd20);
		rst_n <= 1'b0;
		settle(2);
		chk("reset outputs", 32'h0, {27'h0, irq, pwm});
		rst_n <= 1'b1;
		settle(1);
		rchk("reset control", 12'h008, 32'h0);
		rchk("reset capture", 12'h050, 32'h0);
		finish_test();
	end
endmodule
